// file: core/snv_map.svh
// snv_map.svh: addresses, register map, codes and timing of the slave logic
// assumes: included by bare name into the design modules and the bench
`ifndef SNV_MAP_SVH
`define SNV_MAP_SVH

`define SNV_MEM_DEV_ADDR 7'h50
`define SNV_CTL_DEV_ADDR 7'h18
`define SNV_MEM_DEPTH 8192
`define SNV_MEM_LAST 13'h1FFF
`define SNV_MEM_ONE 13'h0001
`define SNV_MEM_HI_MASK 8'hE0
`define SNV_BYTE_BITS 4'h8
`define SNV_REG_MCR 8'h00
`define SNV_REG_SN_FIRST 8'h01
`define SNV_REG_SN_LAST 8'h08
`define SNV_REG_LAST_RD 8'h0C
`define SNV_REG_CMD 8'hAA
`define SNV_REG_ONE 8'h01
`define SNV_MCR_LOCK 0
`define SNV_CMD_STORE 8'h3C
`define SNV_CMD_RECALL 8'h60
// identification fields, values arbitrary
`define SNV_ID_BANK 3'h2
`define SNV_ID_MFR 8'h5A
`define SNV_ID_PRODUCT 14'h0A5B
`define SNV_ID_DENSITY 4'h3
`define SNV_ID_REV 3'h1
`define SNV_CLK_NS 4
`define SNV_EXEC_NS 2000
`define SNV_EXEC_CYC ((`SNV_EXEC_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
`define SNV_PIN_RST 3'h3

`endif

// file: core/snv_pkg.sv
// snv_pkg: types shared by the slave logic
// assumes: nothing beyond a SystemVerilog compiler
package snv_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_MADDR_HI = 3'b010,
        ST_MADDR_LO = 3'b011,
        ST_CADDR = 3'b100,
        ST_WDATA = 3'b101,
        ST_RDATA = 3'b110
    } snv_state_t;
endpackage

// file: core/snv_sync.sv
// snv_sync: two-stage synchroniser for the bus pins and the store request
// assumes: inputs asynchronous to clk; reset level is the idle bus
`include "snv_map.svh"
`timescale 1ns/1ns
`default_nettype none
module snv_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] d,
    output logic [2:0] q
);
    logic [2:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= `SNV_PIN_RST;
            q <= `SNV_PIN_RST;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: core/snv_mem.sv
// snv_mem: 8K x 8 byte array, registered read port
// assumes: write and read address from the same clock domain
`include "snv_map.svh"
`timescale 1ns/1ns
`default_nettype none
module snv_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [12:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [12:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [`SNV_MEM_DEPTH];

    // array has no reset: contents come from bus writes, outside this block
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// file: core/snv_top.sv
// snv_top: i2c slave access of the serial nvram (memory and control slaves)
// assumes: scl/sda/store pins asynchronous; open-drain sda resolved outside
// Operation
// - address byte with lsb one starts a read from the counter
// - counter points past the last byte read or written
// - memory counter increments each byte, wraps to zero after top
// - control writes auto-increment until stop or last writable byte
// - write to non-writable location: nack data, stop, hold counter
// - after command write counter holds; next read starts at zero
// - control write to nonexistent address nacked after address byte
// - random control read of nonexistent address nacked after address
// - locked: only command and control register take data
// - control reads wrap to zero after last readable location
// - read starting at command location delivers from location zero
// - serial number sits at control locations one through eight
// - serial bytes reset to zero, no checksum computed
// - store copies serial bytes and control register to nonvolatile
// - without store, lock and serial bytes come up zero
// - locked serial writes nacked; unlocked rewritable any time
// - serial reads return the current written values
// - 32-bit read-only id: maker, product, density, revision fields
// - maker field: three bank bits above eight number bits
// - command write executes; busy nacks selection; unknown is no-op
`include "snv_map.svh"
`timescale 1ns/1ns
`default_nettype none
module snv_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic STORE_REQ,
    output logic BUSY,
    output logic SERIAL_LOCK
);
    logic [2:0] pins_s;
    logic scl_d_reg, sda_d_reg, store_d_reg, busy_reg, in_ack_reg, ack_next;
    logic oe_next, ack_w, sda_oe_reg, sda_out_reg, mack_reg, ctl_sel_reg;
    snv_pkg::snv_state_t st_reg, st_next, nxt_reg, nxt_next, nxt_w;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sr_reg, tx_reg, tx_next, mem_rdata;
    logic [4:0] hi_reg;
    logic [12:0] mem_ptr_reg;
    logic [7:0] ctl_ptr_reg, mcr_reg, nv_mcr_reg;
    logic [7:0] sn_reg [8], nv_sn_reg [8];
    logic [9:0] busy_cnt_reg;
    snv_sync u_sync (
        .clk(CLK),
        .rst(RST),
        .d({STORE_REQ, SDA_IN, SCL}),
        .q(pins_s)
    );
    wire scl_s = pins_s[0];
    wire sda_s = pins_s[1];
    wire store_s = pins_s[2];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire rx_state = (st_reg != snv_pkg::ST_IDLE) &&
                    (st_reg != snv_pkg::ST_RDATA);
    wire cnt_full = (cnt_reg == `SNV_BYTE_BITS);
    wire shift_in = scl_rise & ~in_ack_reg & rx_state & ~cnt_full;
    wire byte_end = scl_fall & ~in_ack_reg & cnt_full &
                    (st_reg != snv_pkg::ST_IDLE);
    wire ack_end = scl_fall & in_ack_reg;
    wire in_rd = (st_reg == snv_pkg::ST_RDATA);
    wire in_wr = (st_reg == snv_pkg::ST_WDATA);
    // slave selection and address checks
    wire hit_mem = (sr_reg[7:1] == `SNV_MEM_DEV_ADDR);
    wire hit_ctl = (sr_reg[7:1] == `SNV_CTL_DEV_ADDR);
    wire dev_ok = (hit_mem | hit_ctl) & ~busy_reg;
    wire hi_ok = ((sr_reg & `SNV_MEM_HI_MASK) == 8'h00);
    wire caddr_ok = (sr_reg <= `SNV_REG_LAST_RD) ||
                    (sr_reg == `SNV_REG_CMD);
    wire lock = mcr_reg[`SNV_MCR_LOCK];
    wire ptr_sn = (ctl_ptr_reg >= `SNV_REG_SN_FIRST) &&
                  (ctl_ptr_reg <= `SNV_REG_SN_LAST);
    wire ptr_cmd = (ctl_ptr_reg == `SNV_REG_CMD);
    wire writable = (ctl_ptr_reg == `SNV_REG_MCR) | ptr_cmd |
                    (ptr_sn & ~lock);
    // byte-level effects
    wire wr_byte = byte_end & in_wr;
    wire mem_we = wr_byte & ~ctl_sel_reg;
    wire ctl_wr = wr_byte & ctl_sel_reg & writable;
    wire mem_rd_done = byte_end & in_rd & ~ctl_sel_reg;
    wire ctl_rd_done = byte_end & in_rd & ctl_sel_reg;
    wire mem_load = byte_end & (st_reg == snv_pkg::ST_MADDR_LO);
    wire ctl_load = byte_end & (st_reg == snv_pkg::ST_CADDR) & caddr_ok;
    wire cmd_wr = ctl_wr & ptr_cmd;
    wire store_go = (store_s & ~store_d_reg) |
                    (cmd_wr & (sr_reg == `SNV_CMD_STORE));
    wire recall_go = cmd_wr & (sr_reg == `SNV_CMD_RECALL);
    // control read pointer: out-of-map positions read as location zero
    wire [7:0] eff_ptr = (ctl_ptr_reg > `SNV_REG_LAST_RD) ?
                         `SNV_REG_MCR : ctl_ptr_reg;
    wire eff_sn = (eff_ptr >= `SNV_REG_SN_FIRST) &&
                  (eff_ptr <= `SNV_REG_SN_LAST);
    wire [31:0] id_word = {`SNV_ID_BANK, `SNV_ID_MFR, `SNV_ID_PRODUCT,
                           `SNV_ID_DENSITY, `SNV_ID_REV};
    wire [7:0] id_sel = `SNV_REG_LAST_RD - eff_ptr;
    wire [1:0] id_idx = id_sel[1:0];
    wire [7:0] id_byte = id_word[{id_idx, 3'b000} +: 8];
    wire [7:0] sn_sel = eff_ptr - `SNV_REG_SN_FIRST;
    wire [7:0] ctl_rdata = (eff_ptr == `SNV_REG_MCR) ? mcr_reg :
                           eff_sn ? sn_reg[sn_sel[2:0]] : id_byte;
    wire [7:0] rd_byte = ctl_sel_reg ? ctl_rdata : mem_rdata;
    wire go_rd = ~in_rd | ~mack_reg;
    snv_mem u_mem (
        .clk(CLK),
        .rst(RST),
        .we(mem_we),
        .waddr(mem_ptr_reg),
        .wdata(sr_reg),
        .raddr(mem_ptr_reg),
        .rdata(mem_rdata)
    );
    // ack decision at the end of each received byte
    always_comb begin
        ack_w = 1'b0;
        nxt_w = snv_pkg::ST_IDLE;
        case (st_reg)
            snv_pkg::ST_DEVADDR: begin
                ack_w = dev_ok;
                if (dev_ok && sr_reg[0]) begin
                    nxt_w = snv_pkg::ST_RDATA;
                end else if (dev_ok) begin
                    nxt_w = hit_ctl ? snv_pkg::ST_CADDR :
                                      snv_pkg::ST_MADDR_HI;
                end
            end
            snv_pkg::ST_MADDR_HI: begin
                ack_w = hi_ok;
                nxt_w = hi_ok ? snv_pkg::ST_MADDR_LO : snv_pkg::ST_IDLE;
            end
            snv_pkg::ST_MADDR_LO: begin
                ack_w = 1'b1;
                nxt_w = snv_pkg::ST_WDATA;
            end
            snv_pkg::ST_CADDR: begin
                ack_w = caddr_ok;
                nxt_w = caddr_ok ? snv_pkg::ST_WDATA : snv_pkg::ST_IDLE;
            end
            snv_pkg::ST_WDATA: begin
                ack_w = ~ctl_sel_reg | writable;
                nxt_w = ack_w ? snv_pkg::ST_WDATA : snv_pkg::ST_IDLE;
            end
            snv_pkg::ST_RDATA: begin
                nxt_w = snv_pkg::ST_RDATA;
            end
            default: nxt_w = snv_pkg::ST_IDLE;
        endcase
    end
    // bit engine: start/stop win over any bit activity
    always_comb begin
        st_next = st_reg;
        nxt_next = nxt_reg;
        cnt_next = cnt_reg;
        ack_next = in_ack_reg;
        oe_next = sda_oe_reg;
        tx_next = tx_reg;
        if (start_c) begin
            st_next = snv_pkg::ST_DEVADDR;
            cnt_next = 4'h0;
            ack_next = 1'b0;
            oe_next = 1'b0;
        end else if (stop_c) begin
            st_next = snv_pkg::ST_IDLE;
            ack_next = 1'b0;
            oe_next = 1'b0;
        end else if (shift_in) begin
            cnt_next = 4'(cnt_reg + 4'h1);
        end else if (byte_end) begin
            ack_next = 1'b1;
            oe_next = ack_w;
            nxt_next = nxt_w;
        end else if (ack_end) begin
            ack_next = 1'b0;
            cnt_next = 4'h0;
            oe_next = 1'b0;
            st_next = (nxt_reg == snv_pkg::ST_RDATA) ? snv_pkg::ST_IDLE :
                                                        nxt_reg;
            if (nxt_reg == snv_pkg::ST_RDATA && go_rd) begin
                st_next = snv_pkg::ST_RDATA;
                oe_next = ~rd_byte[7];
                tx_next = {rd_byte[6:0], 1'b0};
                cnt_next = 4'h1;
            end
        end else if (scl_fall && in_rd && !in_ack_reg) begin
            oe_next = ~tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
            cnt_next = 4'(cnt_reg + 4'h1);
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg <= snv_pkg::ST_IDLE;
            nxt_reg <= snv_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            in_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            tx_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            nxt_reg <= nxt_next;
            cnt_reg <= cnt_next;
            in_ack_reg <= ack_next;
            sda_oe_reg <= oe_next;
            tx_reg <= tx_next;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            store_d_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            sr_reg <= 8'h00;
            mack_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            store_d_reg <= store_s;
            sda_out_reg <= 1'b0;
            sr_reg <= shift_in ? {sr_reg[6:0], sda_s} : sr_reg;
            mack_reg <= (scl_rise & in_ack_reg) ? sda_s : mack_reg;
        end
    end
    // slave choice only changes on an acknowledged address byte
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl_sel_reg <= 1'b0;
            hi_reg <= 5'h00;
        end else begin
            if (byte_end && st_reg == snv_pkg::ST_DEVADDR && dev_ok) begin
                ctl_sel_reg <= hit_ctl;
            end
            if (byte_end && st_reg == snv_pkg::ST_MADDR_HI) begin
                hi_reg <= sr_reg[4:0];
            end
        end
    end
    // memory counter: natural 13-bit wrap gives the top-to-zero roll
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mem_ptr_reg <= 13'h0000;
        end else if (mem_load) begin
            mem_ptr_reg <= {hi_reg, sr_reg};
        end else if (mem_we || mem_rd_done) begin
            mem_ptr_reg <= 13'(mem_ptr_reg + `SNV_MEM_ONE);
        end
    end
    // control counter
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl_ptr_reg <= `SNV_REG_MCR;
        end else if (ctl_load) begin
            ctl_ptr_reg <= sr_reg;
        end else if (ctl_wr && !ptr_cmd) begin
            ctl_ptr_reg <= 8'(ctl_ptr_reg + `SNV_REG_ONE);
        end else if (ctl_rd_done) begin
            ctl_ptr_reg <= (eff_ptr == `SNV_REG_LAST_RD) ? `SNV_REG_MCR :
                           8'(eff_ptr + `SNV_REG_ONE);
        end
    end
    // control register and its nonvolatile copy
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mcr_reg <= 8'h00;
            nv_mcr_reg <= 8'h00;
        end else begin
            if (ctl_wr && ctl_ptr_reg == `SNV_REG_MCR) begin
                mcr_reg <= sr_reg;
            end else if (recall_go) begin
                mcr_reg <= nv_mcr_reg;
            end
            if (store_go) begin
                nv_mcr_reg <= mcr_reg;
            end
        end
    end
    // serial number bytes; no checksum is formed over them
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_sn
            wire hit = ctl_wr && (ctl_ptr_reg ==
                       8'(`SNV_REG_SN_FIRST + 8'(gi)));
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    sn_reg[gi] <= 8'h00;
                    nv_sn_reg[gi] <= 8'h00;
                end else begin
                    if (hit) begin
                        sn_reg[gi] <= sr_reg;
                    end else if (recall_go) begin
                        sn_reg[gi] <= nv_sn_reg[gi];
                    end
                    if (store_go) begin
                        nv_sn_reg[gi] <= sn_reg[gi];
                    end
                end
            end
        end
    endgenerate
    // execution window; any command, known or not, holds the bus off
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_cnt_reg <= 10'h000;
            busy_reg <= 1'b0;
        end else if (cmd_wr || store_go) begin
            busy_cnt_reg <= 10'(`SNV_EXEC_CYC);
            busy_reg <= 1'b1;
        end else if (busy_cnt_reg != 10'h000) begin
            busy_cnt_reg <= 10'(busy_cnt_reg - 10'h001);
            busy_reg <= (busy_cnt_reg != 10'h001);
        end
    end
    assign SDA_OUT = sda_out_reg;
    assign SDA_OE = sda_oe_reg;
    assign BUSY = busy_reg;
    assign SERIAL_LOCK = mcr_reg[`SNV_MCR_LOCK];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_READ_SELECT: assert property (
        byte_end && st_reg == snv_pkg::ST_DEVADDR && dev_ok && sr_reg[0]
        |=> in_ack_reg && sda_oe_reg && nxt_reg == snv_pkg::ST_RDATA)
        else $error("read select not acknowledged");
    AST_MEM_INC: assert property (
        (mem_we || mem_rd_done) && !start_c
        |=> mem_ptr_reg == 13'($past(mem_ptr_reg) + `SNV_MEM_ONE))
        else $error("memory counter did not advance");
    AST_MEM_WRAP: assert property (
        mem_rd_done && mem_ptr_reg == `SNV_MEM_LAST
        |=> mem_ptr_reg == 13'h0000)
        else $error("memory counter did not wrap");
    AST_BAD_ADDR: assert property (
        byte_end && st_reg == snv_pkg::ST_CADDR && !caddr_ok
        |=> !sda_oe_reg && $stable(ctl_ptr_reg))
        else $error("bad control address not refused");
    AST_CMD_HOLD: assert property (
        cmd_wr |=> ctl_ptr_reg == `SNV_REG_CMD ##0 busy_reg)
        else $error("command write moved the counter");
    AST_LOCK_NACK: assert property (
        wr_byte && ctl_sel_reg && lock && ptr_sn
        |=> !sda_oe_reg && $stable(ctl_ptr_reg))
        else $error("locked serial write accepted");
    AST_RD_WRAP: assert property (
        ctl_rd_done && eff_ptr == `SNV_REG_LAST_RD
        |=> ctl_ptr_reg == `SNV_REG_MCR)
        else $error("control read did not wrap");
    AST_BUSY_NACK: assert property (
        byte_end && st_reg == snv_pkg::ST_DEVADDR && busy_reg
        |=> !sda_oe_reg [*2])
        else $error("selection acknowledged while busy");
    AST_STORE: assert property (
        store_go |=> nv_mcr_reg == $past(mcr_reg))
        else $error("store missed control register");
    COV_MEM_READ: cover property (mem_rd_done ##[1:1000] mem_rd_done);
    COV_CTL_WRITE: cover property (ctl_wr && ptr_sn);
    COV_LOCK_NACK: cover property (wr_byte && ctl_sel_reg && !writable);
    COV_CMD: cover property (cmd_wr ##1 busy_reg);
endmodule
`default_nettype wire

// file: bench/snv_master.sv
// snv_master: i2c bus master model for the slave access logic
// assumes: bench resolves sda with a pull-up; clk runs at 4 ns
`timescale 1ns/1ns
`default_nettype none
module snv_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // extra clk cycles of scl low, to act as a slow master
    int stretch = 0;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // serves as repeated start too, so a random read never sees stop
    task automatic start;
        tick(3);
        sda_drv = 1'b1;
        tick(3 + stretch);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask
    // data moves only while scl low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        tick(3);
        sda_drv = b;
        tick(3 + stretch);
        scl = 1'b1;
        tick(3);
        s = sda;
        tick(3);
        scl = 1'b0;
    endtask
    task automatic stop;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(6);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // master ack low asks for the next byte, high ends the read
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// file: bench/snv_top_bench.sv
// snv_top_bench: self-checking bench of the i2c slave access logic
// assumes: snv_master drives scl and sda; sda has a pull-up
`timescale 1ns/1ns
`default_nettype none
`include "snv_map.svh"
module snv_top_bench;
    logic clk, rst, store_req, sda_out, sda_oe, busy, serial_lock;
    logic scl, m_sda, ack;
    logic [7:0] d;
    logic [7:0] sn [1:8];
    wire logic sda_line;
    wire logic [31:0] id_word;
    int err_total = 0;
    int n_compared = 0;
    // released sda floats high, so a missing ack reads as one
    assign sda_line = (sda_oe ? sda_out : 1'b1) & m_sda;
    // fields placed by their bit positions, not by concatenation order
    assign id_word = (32'(`SNV_ID_BANK) << 29) | (32'(`SNV_ID_MFR) << 21) |
        (32'(`SNV_ID_PRODUCT) << 7) | (32'(`SNV_ID_DENSITY) << 3) |
        32'(`SNV_ID_REV);
    snv_top dut (
        .CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .STORE_REQ(store_req),
        .BUSY(busy), .SERIAL_LOCK(serial_lock)
    );
    snv_master m (.clk(clk), .sda(sda_line), .scl(scl), .sda_drv(m_sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            err_total++;
            $display("wrong value at %0t: busy stuck", $time);
            complete_run();
        end
    endtask
    task automatic addr_ctl(input logic [7:0] a, output logic ok);
        m.start();
        m.send({`SNV_CTL_DEV_ADDR, 1'b0}, ok);
        if (ok === 1'b1) m.send(a, ok);
    endtask
    task automatic addr_mem(input logic [7:0] hi, input logic [7:0] lo,
        output logic ok);
        m.start();
        m.send({`SNV_MEM_DEV_ADDR, 1'b0}, ok);
        m.send(hi, ok);
        if (ok === 1'b1) m.send(lo, ok);
    endtask
    task automatic rd_open(input logic [6:0] dev);
        m.start();
        m.send({dev, 1'b1}, ack);
        chk({7'h00, ack}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] exp, input logic last);
        m.recv(last, d);
        chk(d, exp);
    endtask
    // one control byte written, acked, and any command let run out
    task automatic wr_ctl(input logic [7:0] a, input logic [7:0] v);
        addr_ctl(a, ack);
        m.send(v, ack);
        m.stop();
        chk({7'h00, ack}, 8'h01);
        wait_idle();
    endtask
    task automatic sc_reset_map;
        chk({7'h00, serial_lock}, 8'h00);
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(8'h00, 1'b0);
        for (int i = 1; i <= 8; i++) rd_chk(8'h00, 1'b0);
        for (int i = 3; i >= 0; i--) rd_chk(id_word[i*8 +: 8], 1'b0);
        rd_chk(8'h00, 1'b1);
        m.stop();
    endtask
    task automatic sc_serial;
        addr_ctl(`SNV_REG_SN_FIRST, ack);
        for (int i = 1; i <= 8; i++) begin
            sn[i] = 8'h10 + 8'(i);
            m.send(sn[i], ack);
            chk({7'h00, ack}, 8'h01);
        end
        m.send(8'hEE, ack);
        chk({7'h00, ack}, 8'h00);
        m.send(8'hEF, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(id_word[31:24], 1'b1);
        m.stop();
        addr_ctl(`SNV_REG_SN_FIRST, ack);
        rd_open(`SNV_CTL_DEV_ADDR);
        for (int i = 1; i <= 8; i++) rd_chk(sn[i], i == 8);
        m.stop();
    endtask
    task automatic sc_bad_addr;
        addr_ctl(8'h0D, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        addr_ctl(8'h20, ack);
        chk({7'h00, ack}, 8'h00);
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(id_word[31:24], 1'b1);
        m.stop();
        m.start();
        m.send(8'hFE, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
    endtask
    task automatic sc_lock;
        addr_ctl(`SNV_REG_MCR, ack);
        m.send(8'h01, ack);
        m.stop();
        chk({7'h00, serial_lock}, 8'h01);
        addr_ctl(8'h03, ack);
        chk({7'h00, ack}, 8'h01);
        m.send(8'h77, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(sn[3], 1'b1);
        m.stop();
    endtask
    task automatic sc_command;
        addr_ctl(`SNV_REG_CMD, ack);
        m.send(8'h00, ack);
        chk({7'h00, ack}, 8'h01);
        m.stop();
        chk({7'h00, busy}, 8'h01);
        m.start();
        m.send({`SNV_MEM_DEV_ADDR, 1'b0}, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        wait_idle();
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(8'h01, 1'b1);
        m.stop();
        addr_ctl(`SNV_REG_CMD, ack);
        rd_open(`SNV_CTL_DEV_ADDR);
        rd_chk(8'h01, 1'b0);
        rd_chk(sn[1], 1'b1);
        m.stop();
        store_req = 1'b1;
        repeat (8) @(negedge clk);
        store_req = 1'b0;
        wait_idle();
        // store code saves a clear lock; recall must bring it back clear
        wr_ctl(`SNV_REG_MCR, 8'h00);
        chk({7'h00, serial_lock}, 8'h00);
        wr_ctl(`SNV_REG_CMD, `SNV_CMD_STORE);
        wr_ctl(`SNV_REG_MCR, 8'h01);
        chk({7'h00, serial_lock}, 8'h01);
        wr_ctl(`SNV_REG_CMD, `SNV_CMD_RECALL);
        chk({7'h00, serial_lock}, 8'h00);
    endtask
    task automatic sc_memory;
        addr_mem(8'hE0, 8'h00, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        addr_mem(8'h1F, 8'hFF, ack);
        for (int i = 0; i < 3; i++) begin
            m.send(8'hA0 + 8'(i), ack);
            chk({7'h00, ack}, 8'h01);
        end
        m.stop();
        addr_mem(8'h1F, 8'hFF, ack);
        rd_open(`SNV_MEM_DEV_ADDR);
        rd_chk(8'hA0, 1'b0);
        rd_chk(8'hA1, 1'b1);
        m.stop();
        // control pointer moves must leave the memory counter alone
        addr_ctl(`SNV_REG_SN_FIRST, ack);
        m.stop();
        rd_open(`SNV_MEM_DEV_ADDR);
        rd_chk(8'hA2, 1'b1);
        m.stop();
    endtask
    initial begin
        rst = 1'b1;
        store_req = 1'b0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        sc_reset_map();
        sc_serial();
        sc_bad_addr();
        m.stretch = 9;
        sc_lock();
        m.stretch = 0;
        sc_command();
        sc_memory();
        complete_run();
    end
endmodule
`default_nettype wire
